/* ecp_pkg.sv */
`default_nettype none
package ecp_pkg;
	// Register offsets from the port base
	localparam logic [10:0] OFS_DATA = 11'h000;
	localparam logic [10:0] OFS_STATUS = 11'h001;
	localparam logic [10:0] OFS_CONTROL = 11'h002;
	localparam logic [10:0] OFS_FIFO = 11'h400;
	localparam logic [10:0] OFS_CFGB = 11'h401;
	localparam logic [10:0] OFS_ECR = 11'h402;
	// Mode field codes
	localparam logic [2:0] MODE_SPP = 3'h0;
	localparam logic [2:0] MODE_BIDIR = 3'h1;
	localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_EPP = 3'h4;
	localparam logic [2:0] MODE_RSVD = 3'h5;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_CONFIG = 3'h7;
	// Extended control field positions
	localparam int ECR_MODE_LSB = 5;
	localparam int ECR_FAULT_DIS = 4;
	localparam int ECR_DMA_EN = 3;
	localparam int ECR_SVC = 2;
	// Port control field positions
	localparam int DCR_DIR = 5;
	localparam int DCR_ACK_IE = 4;
	localparam int DCR_SELIN = 3;
	localparam int DCR_INIT = 2;
	localparam int DCR_AUTOFD = 1;
	localparam int DCR_STROBE = 0;
	// Reset values and fixed read bits
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic FAULT_DIS_RESET = 1'b1;
	localparam logic DMA_EN_RESET = 1'b0;
	localparam logic SVC_RESET = 1'b1;
	localparam logic [5:0] DCR_RESET = 6'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [5:0] CFGB_RESET = 6'h3f;
	localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
	// FIFO shape and service thresholds
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FWD_FREE_THRESHOLD = 5'h08;
	localparam logic [4:0] REV_FILL_THRESHOLD = 5'h08;
endpackage : ecp_pkg
`default_nettype wire

/* ecp_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ecp_fifo_if #(parameter int W = 9, parameter int CW = 5);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	logic clear;
	logic [CW-1:0] count;
	modport fifo (input in_valid, in_data, out_ready, clear,
		output in_ready, out_valid, out_data, count);
	modport user (output in_valid, in_data, out_ready, clear,
		input in_ready, out_valid, out_data, count);
endinterface : ecp_fifo_if
`default_nettype wire

/* ecp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ecp_mem #(parameter int W = 9, parameter int AW = 4) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Registered read port
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : ecp_mem
`default_nettype wire

/* ecp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ecp_fifo #(parameter int W = 9, parameter int D = 16) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Both sides
	ecp_fifo_if.fifo f
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(D);
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic fresh_r;
	wire push = f.in_valid & f.in_ready;
	wire pop = f.out_valid & f.out_ready;
	wire [AW-1:0] rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	// Read port lags a write to the head slot by one cycle
	wire fresh_nxt = push & (wr_ptr_r == rd_ptr_nxt);

	assign f.in_ready = (count_r != FULL_COUNT) & ~f.clear;
	assign f.out_valid = (count_r != '0) & ~fresh_r & ~f.clear;
	assign f.count = count_r;

	ecp_mem #(.W(W), .AW(AW)) u_mem (
		.clk(clk),
		.we(push),
		.waddr(wr_ptr_r),
		.wdata(f.in_data),
		.raddr(rd_ptr_nxt),
		.rdata(f.out_data)
	);

	always_ff @(posedge clk) begin
		if (!rst_n || f.clear) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			fresh_r <= 1'b0;
		end else begin
			wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			fresh_r <= fresh_nxt;
		end
	end
endmodule : ecp_fifo
`default_nettype wire

/* ecp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ecp_port (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host I/O cycle
	input wire logic [10:0] ADDR,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic [7:0] DIN,
	output logic [7:0] DOUT,
	output logic DOE,
	// DMA
	input wire logic DACK_N,
	input wire logic TC,
	output logic PDRQ,
	// Interrupt and option
	output logic IRQ,
	input wire logic EPP_EN,
	output logic EPP_ACTIVE,
	// Port data lines
	input wire logic [7:0] PD_IN,
	output logic [7:0] PD_OUT,
	output logic PD_OE,
	// Port control lines
	output logic STROBE_N,
	output logic AUTOFD_N,
	output logic INIT_N,
	output logic SELIN_N,
	// Port status lines
	input wire logic BUSY,
	input wire logic ACK_N,
	input wire logic PERROR,
	input wire logic SELECT,
	input wire logic FAULT_N
);
	typedef enum logic [1:0] {F_IDLE, F_SETUP, F_STROBE, F_HOLD} ecp_fwd_type;
	typedef enum logic [1:0] {R_IDLE, R_REQ, R_ACK} ecp_rev_type;

	function automatic logic is_fifo_mode(input logic [2:0] m);
		is_fifo_mode = (m == ecp_pkg::MODE_COMPAT_FIFO_PORT) || (m == ecp_pkg::MODE_ECP)
			|| (m == ecp_pkg::MODE_TEST);
	endfunction : is_fifo_mode

	function automatic logic is_plain_mode(input logic [2:0] m);
		is_plain_mode = (m == ecp_pkg::MODE_SPP) || (m == ecp_pkg::MODE_BIDIR);
	endfunction : is_plain_mode

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [2:0] mode_r;
	logic fault_dis_r;
	logic dma_en_r;
	logic svc_r;
	logic [5:0] dcr_r;
	logic [7:0] data_r;
	logic [5:0] cfgb_r;
	logic [7:0] rd_data_r;
	logic irq_r;
	logic ior_q_r;
	logic iow_q_r;
	logic fault_q_r;
	logic ack_q_r;
	ecp_fwd_type fwd_r;
	ecp_rev_type rev_r;
	logic [7:0] pd_out_r;
	logic hostack_r;

	ecp_fifo_if #(.W(ecp_pkg::FIFO_WIDTH), .CW(5)) fq ();

	ecp_fifo #(.W(ecp_pkg::FIFO_WIDTH), .D(ecp_pkg::FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.f(fq)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	wire m_spp = mode_r == ecp_pkg::MODE_SPP;
	wire m_bidir = mode_r == ecp_pkg::MODE_BIDIR;
	wire m_compat_fifo_port = mode_r == ecp_pkg::MODE_COMPAT_FIFO_PORT;
	wire m_ecp = mode_r == ecp_pkg::MODE_ECP;
	wire m_test = mode_r == ecp_pkg::MODE_TEST;
	wire m_cfg = mode_r == ecp_pkg::MODE_CONFIG;
	wire m_fifo = is_fifo_mode(mode_r);
	// Direction has no effect in 000 and 010
	wire dir = dcr_r[ecp_pkg::DCR_DIR] & ~m_spp & ~m_compat_fifo_port;
	wire xfer_fwd = ~dir;

	////////////////////////////////////////////////////////////////////////////
	// Host cycle decode

	wire wr_go = ~IOW_N & iow_q_r;
	wire rd_go = ~IOR_N & ior_q_r;
	wire io_wr = wr_go & DACK_N;
	wire io_rd = rd_go & DACK_N;
	wire dma_cyc = ~DACK_N & (wr_go | rd_go);
	wire a_data = ADDR == ecp_pkg::OFS_DATA;
	wire a_fifo = ADDR == ecp_pkg::OFS_FIFO;
	wire wr_data = io_wr & a_data & ~m_ecp;
	wire wr_afifo = io_wr & a_data & m_ecp & xfer_fwd;
	wire wr_dfifo = (io_wr & a_fifo | wr_go & ~DACK_N) & m_fifo
		& (m_test | xfer_fwd);
	wire wr_dcr = io_wr & (ADDR == ecp_pkg::OFS_CONTROL);
	wire wr_cfgb = io_wr & (ADDR == ecp_pkg::OFS_CFGB) & m_cfg;
	wire wr_ecr = io_wr & (ADDR == ecp_pkg::OFS_ECR);
	wire rd_pop = (io_rd & a_fifo | rd_go & ~DACK_N)
		& (m_test | m_ecp & dir);

	////////////////////////////////////////////////////////////////////////////
	// Extended control write

	wire [2:0] new_mode = DIN[7:ecp_pkg::ECR_MODE_LSB];
	wire mode_ok = (is_plain_mode(mode_r) | is_plain_mode(new_mode))
		& (new_mode != ecp_pkg::MODE_RSVD)
		& ((new_mode != ecp_pkg::MODE_EPP) | EPP_EN);
	wire [2:0] mode_nxt = (wr_ecr & mode_ok) ? new_mode : mode_r;
	wire fault_dis_nxt = wr_ecr ? DIN[ecp_pkg::ECR_FAULT_DIS] : fault_dis_r;
	wire dma_en_nxt = wr_ecr ? DIN[ecp_pkg::ECR_DMA_EN] : dma_en_r;
	// Only mode 001 may move the direction bit
	wire dir_nxt = m_bidir ? DIN[ecp_pkg::DCR_DIR] : dcr_r[ecp_pkg::DCR_DIR];
	wire [5:0] dcr_nxt = wr_dcr ? {dir_nxt, DIN[4:0]} : dcr_r;

	////////////////////////////////////////////////////////////////////////////
	// Service flag and interrupts

	wire [4:0] free_cnt = 5'(ecp_pkg::FIFO_DEPTH) - fq.count;
	wire thr_hit = xfer_fwd ? (free_cnt >= ecp_pkg::FWD_FREE_THRESHOLD)
		: (fq.count >= ecp_pkg::REV_FILL_THRESHOLD);
	wire tc_hit = dma_cyc & TC;
	wire svc_evt = m_fifo & (dma_en_r ? tc_hit : thr_hit);
	// Clearing write and event together: the event wins
	wire svc_arm = ~svc_r | (wr_ecr & ~DIN[ecp_pkg::ECR_SVC]);
	wire svc_set = svc_evt & svc_arm;
	wire svc_nxt = svc_set | (wr_ecr ? DIN[ecp_pkg::ECR_SVC] : svc_r);
	wire fault_fall = fault_q_r & ~FAULT_N;
	wire fault_rearm = wr_ecr & fault_dis_r & ~DIN[ecp_pkg::ECR_FAULT_DIS] & ~FAULT_N;
	wire fault_evt = m_ecp & (~fault_dis_r & fault_fall | fault_rearm);
	wire ack_evt = dcr_r[ecp_pkg::DCR_ACK_IE] & ~ack_q_r & ACK_N & ~m_fifo;
	// A software write of 1 never pulses: only svc_set does
	wire irq_nxt = svc_set | fault_evt | ack_evt;

	////////////////////////////////////////////////////////////////////////////
	// Read path

	wire fifo_full = ~fq.in_ready & ~m_spp;
	wire fifo_empty = fq.count == 5'h00;
	wire [7:0] ecr_rd = {mode_r, fault_dis_r, dma_en_r, svc_r,
		fifo_full, fifo_empty};
	wire [7:0] data_rd = m_bidir ? PD_IN : data_r;
	wire [7:0] dsr_rd = {~BUSY, ACK_N, PERROR, SELECT, FAULT_N, 3'h7};
	wire [7:0] fifo_rd = m_cfg ? ecp_pkg::CONFIG_A_VALUE
		: (fq.out_valid ? fq.out_data[7:0] : 8'h00);
	wire [7:0] cfgb_rd = m_cfg ? {1'b0, irq_r, cfgb_r} : 8'h00;
	wire [7:0] rd_mux = ~DACK_N ? fifo_rd
		: a_data ? data_rd
		: (ADDR == ecp_pkg::OFS_STATUS) ? dsr_rd
		: (ADDR == ecp_pkg::OFS_CONTROL) ? {2'h3, dcr_r}
		: a_fifo ? fifo_rd
		: (ADDR == ecp_pkg::OFS_CFGB) ? cfgb_rd
		: (ADDR == ecp_pkg::OFS_ECR) ? ecr_rd
		: 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Forward engine

	wire eng_mode = m_compat_fifo_port | m_ecp;
	// In ECP, drive only after the peripheral confirms forward
	wire fwd_ok = eng_mode & xfer_fwd & (~m_ecp | PERROR);
	wire fwd_pop = (fwd_r == F_IDLE) & fwd_ok & fq.out_valid & ~BUSY;
	wire fwd_strobe = fwd_r == F_STROBE;

	always_ff @(posedge CLK) begin
		if (!RST_N || !eng_mode) begin
			fwd_r <= F_IDLE;
		end else begin
			unique case (fwd_r)
				F_IDLE: fwd_r <= fwd_pop ? F_SETUP : F_IDLE;
				F_SETUP: fwd_r <= F_STROBE;
				F_STROBE: fwd_r <= BUSY ? F_HOLD : F_STROBE;
				F_HOLD: fwd_r <= BUSY ? F_HOLD : F_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pd_out_r <= ecp_pkg::DATA_RESET;
			hostack_r <= 1'b1;
		end else if (fwd_pop) begin
			pd_out_r <= fq.out_data[7:0];
			hostack_r <= ~fq.out_data[8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reverse engine

	wire rev_ok = m_ecp & dir & ~PERROR;
	wire rev_take = (rev_r == R_REQ) & ~ACK_N;
	// Command bytes are dropped: no decompression on the reverse path
	wire rev_push = rev_take & BUSY;

	always_ff @(posedge CLK) begin
		if (!RST_N || !rev_ok) begin
			rev_r <= R_IDLE;
		end else begin
			unique case (rev_r)
				R_IDLE: rev_r <= fq.in_ready ? R_REQ : R_IDLE;
				R_REQ: rev_r <= rev_take ? R_ACK : R_REQ;
				R_ACK: rev_r <= ACK_N ? R_IDLE : R_ACK;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFO hookup

	assign fq.clear = m_spp;
	assign fq.in_valid = wr_afifo | wr_dfifo | rev_push;
	assign fq.in_data = rev_push ? {1'b0, PD_IN} : {wr_afifo, DIN};
	assign fq.out_ready = fwd_pop | rd_pop;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_r <= ecp_pkg::MODE_RESET;
			fault_dis_r <= ecp_pkg::FAULT_DIS_RESET;
			dma_en_r <= ecp_pkg::DMA_EN_RESET;
			svc_r <= ecp_pkg::SVC_RESET;
			dcr_r <= ecp_pkg::DCR_RESET;
		end else begin
			mode_r <= mode_nxt;
			fault_dis_r <= fault_dis_nxt;
			dma_en_r <= dma_en_nxt;
			svc_r <= svc_nxt;
			dcr_r <= dcr_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			data_r <= ecp_pkg::DATA_RESET;
			cfgb_r <= ecp_pkg::CFGB_RESET;
		end else begin
			data_r <= wr_data ? DIN : data_r;
			cfgb_r <= wr_cfgb ? DIN[5:0] : cfgb_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rd_data_r <= 8'h00;
			irq_r <= 1'b0;
			ior_q_r <= 1'b1;
			iow_q_r <= 1'b1;
			fault_q_r <= 1'b1;
			ack_q_r <= 1'b1;
		end else begin
			// Captured at cycle start so a FIFO pop cannot change it
			rd_data_r <= rd_go ? rd_mux : rd_data_r;
			irq_r <= irq_nxt;
			ior_q_r <= IOR_N;
			iow_q_r <= IOW_N;
			fault_q_r <= FAULT_N;
			ack_q_r <= ACK_N;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign DOUT = rd_data_r;
	assign DOE = ~IOR_N & ~ior_q_r;
	assign IRQ = irq_r;
	assign PDRQ = dma_en_r & ~svc_r & m_fifo
		& (xfer_fwd ? fq.in_ready : fq.out_valid);
	assign EPP_ACTIVE = mode_r == ecp_pkg::MODE_EPP;
	assign PD_OUT = eng_mode ? pd_out_r : data_r;
	assign PD_OE = ~dir & ~(m_ecp & ~PERROR);
	assign STROBE_N = eng_mode ? ~fwd_strobe : ~dcr_r[ecp_pkg::DCR_STROBE];
	assign AUTOFD_N = m_ecp ? (dir ? (rev_r != R_REQ) : hostack_r)
		: ~dcr_r[ecp_pkg::DCR_AUTOFD];
	assign INIT_N = dcr_r[ecp_pkg::DCR_INIT] & ~(m_ecp & dir);
	assign SELIN_N = ~dcr_r[ecp_pkg::DCR_SELIN];
endmodule : ecp_port
`default_nettype wire

/* ecp_port_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ecp_port_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host side
	input wire logic [10:0] ADDR,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic [7:0] DOUT,
	input wire logic DACK_N,
	input wire logic TC,
	input wire logic PDRQ,
	input wire logic IRQ,
	input wire logic EPP_EN,
	input wire logic EPP_ACTIVE,
	// Port side
	input wire logic STROBE_N,
	input wire logic BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_rd(logic [10:0] a);
		!IOR_N && $past(IOR_N) && DACK_N && ADDR == a;
	endsequence
	sequence s_dma_tc;
		!IOW_N && $past(IOW_N) && !DACK_N && TC && PDRQ;
	endsequence
	////////////////////////////////////////
	property p_ecr_flags;
		s_rd(ecp_pkg::OFS_ECR) |=> DOUT[1:0] != 2'h3;
	endproperty
	a_ecr_flags: assert property (p_ecr_flags) else $error("full with empty");
	property p_ecr_mode;
		s_rd(ecp_pkg::OFS_ECR) |=> DOUT[7:5] != ecp_pkg::MODE_RSVD;
	endproperty
	a_ecr_mode: assert property (p_ecr_mode) else $error("reserved mode held");
	property p_epp_entry;
		$rose(EPP_ACTIVE) |-> $past(EPP_EN);
	endproperty
	a_epp_entry: assert property (p_epp_entry) else $error("epp without option");
	property p_cfgb_top;
		s_rd(ecp_pkg::OFS_CFGB) |=> !DOUT[7];
	endproperty
	a_cfgb_top: assert property (p_cfgb_top) else $error("compress bit set");
	property p_irq_pulse;
		IRQ |=> !IRQ;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
	// Terminal count must both interrupt and stop requests
	property p_tc_svc;
		s_dma_tc |-> ##[1:2] (IRQ && !PDRQ);
	endproperty
	a_tc_svc: assert property (p_tc_svc) else $error("tc ignored");
	property p_strobe_hold;
		!STROBE_N && !BUSY && IOW_N |=> !STROBE_N;
	endproperty
	a_strobe_hold: assert property (p_strobe_hold) else $error("strobe early");
	property p_strobe_rest;
		STROBE_N && BUSY && IOW_N |=> STROBE_N;
	endproperty
	a_strobe_rest: assert property (p_strobe_rest) else $error("strobe on busy");
endmodule : ecp_port_chk
bind ecp_port ecp_port_chk chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .IOR_N(IOR_N),
	.IOW_N(IOW_N), .DOUT(DOUT), .DACK_N(DACK_N), .TC(TC), .PDRQ(PDRQ), .IRQ(IRQ),
	.EPP_EN(EPP_EN), .EPP_ACTIVE(EPP_ACTIVE), .STROBE_N(STROBE_N), .BUSY(BUSY));
`default_nettype wire

/* ecp_periph.sv */
`timescale 1ns/1ps
`default_nettype none
module ecp_periph (
	// Clock and response lag
	input wire logic clk,
	input wire logic [3:0] lag,
	// Host-driven lines
	input wire logic strobe_n,
	input wire logic autofd_n,
	input wire logic init_n,
	input wire logic [7:0] pd_out,
	input wire logic fault_req,
	// Peripheral-driven lines
	output logic busy,
	output logic ack_n,
	output logic perror,
	output logic fault_n,
	output logic [7:0] pd_in
);
	logic [8:0] got[$];
	logic [8:0] rq[$];
	logic drv;
	logic [3:0] wait_r;
	assign fault_n = !fault_req;
	initial begin
		busy = 0;
		ack_n = 1;
		perror = 0;
		pd_in = 8'h00;
		drv = 0;
		wait_r = 0;
	end
	////////////////////////////////////////
	always @(posedge clk) begin
		perror <= init_n;
		// Undriven lines wander, so stale data never passes
		if (!drv)
			pd_in <= ~pd_in;
		if (init_n) begin
			ack_n <= 1'b1;
			drv <= 1'b0;
			wait_r <= strobe_n ? 4'h0 : wait_r + 4'h1;
			if (!strobe_n && !busy && wait_r >= lag) begin
				got.push_back({autofd_n, pd_out});
				busy <= 1'b1;
			end else if (strobe_n)
				busy <= 1'b0;
		end else if (!drv && !autofd_n && rq.size() > 0) begin
			drv <= 1'b1;
			pd_in <= rq[0][7:0];
			busy <= rq[0][8];
		end else if (drv && ack_n && !autofd_n)
			ack_n <= 1'b0;
		else if (drv && !ack_n && autofd_n) begin
			ack_n <= 1'b1;
			drv <= 1'b0;
			void'(rq.pop_front());
		end
	end
endmodule : ecp_periph
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [10:0] o_dat = ecp_pkg::OFS_DATA;
	localparam logic [10:0] o_dcr = ecp_pkg::OFS_CONTROL;
	localparam logic [10:0] o_fifo = ecp_pkg::OFS_FIFO;
	localparam logic [10:0] o_cfgb = ecp_pkg::OFS_CFGB;
	localparam logic [10:0] o_ecr = ecp_pkg::OFS_ECR;
	logic CLK, RST_N, IOR_N, IOW_N, DOE, DACK_N, TC, PDRQ, IRQ, EPP_EN, EPP_ACTIVE, PD_OE;
	logic STROBE_N, AUTOFD_N, INIT_N, SELIN_N, BUSY, ACK_N, PERROR, FAULT_N, fault_req;
	logic [10:0] ADDR;
	logic [7:0] DIN, DOUT, PD_IN, PD_OUT;
	logic [8:0] q;
	logic [3:0] lag;
	int bad_count;
	int num_checks;
	ecp_port dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .IOR_N(IOR_N), .IOW_N(IOW_N),
		.DIN(DIN), .DOUT(DOUT), .DOE(DOE), .DACK_N(DACK_N), .TC(TC), .PDRQ(PDRQ), .IRQ(IRQ),
		.EPP_EN(EPP_EN), .EPP_ACTIVE(EPP_ACTIVE), .PD_IN(PD_IN), .PD_OUT(PD_OUT),
		.PD_OE(PD_OE), .STROBE_N(STROBE_N), .AUTOFD_N(AUTOFD_N), .INIT_N(INIT_N),
		.SELIN_N(SELIN_N), .BUSY(BUSY), .ACK_N(ACK_N), .PERROR(PERROR), .SELECT(1'b1),
		.FAULT_N(FAULT_N));
	ecp_periph p (.clk(CLK), .lag(lag), .strobe_n(STROBE_N), .autofd_n(AUTOFD_N),
		.init_n(INIT_N), .pd_out(PD_OUT), .fault_req(fault_req), .busy(BUSY), .ack_n(ACK_N),
		.perror(PERROR), .fault_n(FAULT_N), .pd_in(PD_IN));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(negedge CLK);
		ADDR = a;
		DIN = d;
		IOW_N = 0;
		@(negedge CLK);
		IOW_N = 1;
	endtask : wr
	task automatic rd(input logic [10:0] a);
		@(negedge CLK);
		ADDR = a;
		IOR_N = 0;
		@(negedge CLK);
		@(negedge CLK);
		q = {1'b0, DOUT};
		IOR_N = 1;
	endtask : rd
	// Pulse lasts one cycle, so poll every cycle of a short span
	task automatic wait_irq(input string n, input logic e);
		logic hit;
		hit = 0;
		repeat (8) begin
			@(negedge CLK);
			if (IRQ === 1'b1)
				hit = 1;
		end
		chk(n, {8'h00, hit}, {8'h00, e});
	endtask : wait_irq
	task automatic t_modes;
		wr(o_ecr, 8'ha4);
		rd(o_ecr);
		chk("mode 101", q, 9'h005);
		wr(o_ecr, 8'h84);
		rd(o_ecr);
		chk("epp off", q, 9'h005);
		EPP_EN = 1;
		wr(o_ecr, 8'h84);
		chk("epp on", {8'h00, EPP_ACTIVE}, 9'h001);
		wr(o_ecr, 8'h04);
		wr(o_ecr, 8'h44);
		wr(o_ecr, 8'h64);
		rd(o_ecr);
		chk("mode lock", q & 9'h0e0, 9'h040);
		wr(o_ecr, 8'h04);
		wr(o_ecr, 8'he4);
		rd(o_fifo);
		chk("config a", q, 9'h010);
		rd(o_cfgb);
		chk("config b", q, 9'h03f);
		wr(o_ecr, 8'h04);
	endtask : t_modes
	task automatic t_test;
		wr(o_ecr, 8'hc4);
		for (int i = 0; i < 17; i++)
			wr(o_fifo, 8'(i));
		rd(o_ecr);
		chk("full", q & 9'h003, 9'h002);
		for (int i = 0; i < 16; i++) begin
			rd(o_fifo);
			chk("test_fifo_port", q, 9'(i));
		end
		chk("sent", 9'(p.got.size()), 9'h000);
		rd(o_ecr);
		chk("empty", q & 9'h003, 9'h001);
		// Enable first: the old enable decides the event of the clearing write
		wr(o_ecr, 8'hcc);
		wr(o_ecr, 8'hc8);
		chk("pdrq", {8'h00, PDRQ}, 9'h001);
		DACK_N = 0;
		TC = 1;
		fork wr(o_fifo, 8'h77); wait_irq("tc irq", 1); join
		DACK_N = 1;
		TC = 0;
		rd(o_ecr);
		chk("tc svc", q & 9'h004, 9'h004);
		chk("pdrq off", {8'h00, PDRQ}, 9'h000);
		fork wr(o_ecr, 8'hc0); wait_irq("thr irq", 1); join
		rd(o_ecr);
		chk("thr svc", q & 9'h004, 9'h004);
		wr(o_ecr, 8'h04);
		rd(o_ecr);
		chk("fifo reset", q, 9'h005);
	endtask : t_test
	task automatic t_fwd;
		wr(o_dcr, 8'h04);
		lag = 4'h3;
		wr(o_ecr, 8'h54);
		wr(o_fifo, 8'hc3);
		for (int i = 0; i < 200 && p.got.size() < 1; i++)
			@(negedge CLK);
		chk("compat byte", p.got[0], 9'h1c3);
		wr(o_ecr, 8'h14);
		wr(o_ecr, 8'h64);
		wr(o_dat, 8'h12);
		wr(o_fifo, 8'hab);
		for (int i = 0; i < 200 && p.got.size() < 3; i++)
			@(negedge CLK);
		chk("cmd byte", p.got[1], 9'h012);
		chk("data byte", p.got[2], 9'h1ab);
		wr(o_dcr, 8'h24);
		rd(o_dcr);
		chk("dir lock", q, 9'h0c4);
		wr(o_ecr, 8'h44);
		rd(o_ecr);
		chk("mode stay", q & 9'h0e0, 9'h060);
	endtask : t_fwd
	task automatic t_fault;
		fault_req = 1;
		wait_irq("fault fall", 1);
		wr(o_ecr, 8'h74);
		fork wr(o_ecr, 8'h64); wait_irq("fault rearm", 1); join
		fault_req = 0;
		wr(o_ecr, 8'h74);
		fault_req = 1;
		wait_irq("fault masked", 0);
		fault_req = 0;
	endtask : t_fault
	task automatic t_rev;
		p.rq = '{9'h15a, 9'h005, 9'h13c};
		wr(o_ecr, 8'h34);
		wr(o_dcr, 8'h22);
		rd(o_dat);
		chk("live data", q, 9'h05a);
		chk("pd released", {8'h00, PD_OE}, 9'h000);
		wr(o_dcr, 8'h20);
		wr(o_ecr, 8'h74);
		for (int i = 0; i < 200 && p.rq.size() > 0; i++)
			@(negedge CLK);
		rd(o_fifo);
		chk("rev byte", q, 9'h03c);
		rd(o_ecr);
		chk("rev drained", q & 9'h003, 9'h001);
	endtask : t_rev
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////
	initial begin
		CLK = 0;
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		RST_N = 0;
		ADDR = 0;
		DIN = 0;
		IOR_N = 1;
		IOW_N = 1;
		DACK_N = 1;
		TC = 0;
		EPP_EN = 0;
		fault_req = 0;
		lag = 0;
		q = 0;
		// Count rising edges: the first falling edge may race time zero
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		RST_N = 1;
		rd(o_ecr);
		chk("ecr reset", q, 9'h015);
		t_modes;
		t_test;
		t_fwd;
		t_fault;
		t_rev;
		end_of_test;
	end
	// Whole run needs a few hundred cycles
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
endmodule : tb
`default_nettype wire
